// ==== mux_switch_pkg.sv ====
// constants shared by the switch-matrix slave and the bus controller
//----------------------------------------------------------------------
// Behaviour
// - shutdown clears registers, opens all switches
// - shutdown ignores all bus activity
// - protocol pin selects serial slave or not
// - four direct registers, eight switches each
// - pointer auto-increments over data bytes
// - direct write acts after last bit
// - staged writes wait for copy command
// - master loads staged, then both commands
// - bank A: close one, open, copy, keep
// - bank B: close one, open, copy, keep
// - both commands applied together after B
// - master writes bank A before bank B
// - master starts transfers, makes clock
// - data line open-drain, only pulled low
// - clock line input only, never stretched
// - start, address, register, data, stop
// - address 10011 plus two select pins
// - stop after register byte: pointer only
// - reads from pointer, stop after nack
//----------------------------------------------------------------------
`default_nettype none
package mux_switch_pkg;

  // slave address and register map
  localparam logic [4:0] SLAVE_ADDR_UPPER = 5'h13;
  localparam logic [7:0] REG_DIRECT_BASE = 8'h00;
  localparam logic [7:0] REG_STAGED_BASE = 8'h10;
  localparam logic [7:0] REG_BANK_A_CMD = 8'h14;
  localparam logic [7:0] REG_BANK_B_CMD = 8'h15;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // bank command codes: below OPEN_ALL closes switch number code
  localparam logic [4:0] CMD_OPEN_ALL = 5'h10;
  localparam logic [4:0] CMD_COPY = 5'h11;

  // controller operations
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_STOP = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ_ACK = 3'h4;
  localparam logic [2:0] OP_READ_NACK = 3'h5;

  // controller register map
  localparam logic [7:0] AXI_CMD = 8'h00;
  localparam logic [7:0] AXI_STATUS = 8'h04;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // serial clock timing
  localparam int CORE_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 800;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CORE_PERIOD_NS);

endpackage
`default_nettype wire

// ==== i2c_link_if.sv ====
// open-drain two-wire link between controller and switch slave
`timescale 1ns/1ns
`default_nettype none
interface i2c_link_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // pull-ups: a line is low while any party enables its driver
  assign scl = !scl_m_oe;
  assign sda = !(sda_m_oe || sda_s_oe);

  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// ==== mux_switch_slave.sv ====
// two-wire slave holding the switch-matrix control registers
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module mux_switch_slave (
  input wire logic core_clk,       // system clock
  input wire logic sys_rst,        // async reset, active high
  input wire logic power_down_n,   // shutdown pin, active low
  input wire logic spi_sel,        // protocol select, high = shift path
  input wire logic addr_sel_low,   // address select bit 0
  input wire logic addr_sel_high,  // address select bit 1
  i2c_link_if.slave link,          // serial link
  output logic [31:0] switch_en    // switch enables, 1 = closed
);

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_RX = 7'h08,
    S_RACK = 7'h10,
    S_TX = 7'h20,
    S_TACK = 7'h40
  } slave_state_t;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic scl_prev;
    logic sda_prev;
    slave_state_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic got_ptr;
    logic nack;
    logic cmd_a_pending;
    logic [7:0] ptr;
    logic [7:0] cmd_a;
    logic [7:0] cmd_b;
    logic [3:0][7:0] direct;
    logic [3:0][7:0] staged;
    logic sda_oe;
  } slave_regs_t;

  slave_regs_t cur;
  slave_regs_t nx;

  logic scl_s;
  logic sda_s;
  logic pd_s;
  logic spi_s;
  logic [1:0] asel_s;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rd_byte;

  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------
  // new contents of one bank of sixteen switches
  function automatic logic [15:0] bank_apply(input logic [7:0] cmd,
                                             input logic [15:0] now,
                                             input logic [15:0] stg);
    logic [4:0] code;
    begin
      code = cmd[4:0];
      bank_apply = now;
      if (code < mux_switch_pkg::CMD_OPEN_ALL) begin
        bank_apply = 16'h0001 << code;
      end else if (code == mux_switch_pkg::CMD_OPEN_ALL) begin
        bank_apply = 16'h0000;
      end else if (code == mux_switch_pkg::CMD_COPY) begin
        bank_apply = stg;
      end
    end
  endfunction

  function automatic logic [7:0] reg_read(input slave_regs_t s,
                                          input logic [7:0] a);
    begin
      reg_read = 8'h00;
      if (a[7:2] == mux_switch_pkg::REG_DIRECT_BASE[7:2]) begin
        reg_read = s.direct[a[1:0]];
      end else if (a[7:2] == mux_switch_pkg::REG_STAGED_BASE[7:2]) begin
        reg_read = s.staged[a[1:0]];
      end else if (a == mux_switch_pkg::REG_BANK_A_CMD) begin
        reg_read = s.cmd_a;
      end else if (a == mux_switch_pkg::REG_BANK_B_CMD) begin
        reg_read = s.cmd_b;
      end
    end
  endfunction

  // unmapped addresses take the byte and change nothing
  function automatic slave_regs_t reg_write(input slave_regs_t s,
                                            input logic [7:0] a,
                                            input logic [7:0] d);
    begin
      reg_write = s;
      if (a[7:2] == mux_switch_pkg::REG_DIRECT_BASE[7:2]) begin
        reg_write.direct[a[1:0]] = d;
      end else if (a[7:2] == mux_switch_pkg::REG_STAGED_BASE[7:2]) begin
        reg_write.staged[a[1:0]] = d;
      end else if (a == mux_switch_pkg::REG_BANK_A_CMD) begin
        reg_write.cmd_a = d;
        reg_write.cmd_a_pending = 1'b1;
      end else if (a == mux_switch_pkg::REG_BANK_B_CMD) begin
        reg_write.cmd_b = d;
        // both banks change in the same cycle, only once A was written
        if (s.cmd_a_pending) begin
          reg_write.direct[1:0] = bank_apply(s.cmd_a, s.direct[1:0],
                                             s.staged[1:0]);
          reg_write.direct[3:2] = bank_apply(d, s.direct[3:2],
                                             s.staged[3:2]);
          reg_write.cmd_a_pending = 1'b0;
        end
      end
    end
  endfunction

  //--------------------------------------------------------------------
  // synchronised pins and line events
  //--------------------------------------------------------------------
  assign scl_s = cur.sync2[0];
  assign sda_s = cur.sync2[1];
  assign pd_s = cur.sync2[2];
  assign spi_s = cur.sync2[3];
  assign asel_s = cur.sync2[5:4];
  assign start_seen = scl_s && cur.scl_prev && cur.sda_prev && !sda_s;
  assign stop_seen = scl_s && cur.scl_prev && !cur.sda_prev && sda_s;
  assign scl_rise = scl_s && !cur.scl_prev;
  assign scl_fall = !scl_s && cur.scl_prev;
  assign rd_byte = reg_read(cur, cur.ptr);

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  always_comb begin
    nx = cur;
    if (!pd_s) begin
      // registers cleared, switches open, bus ignored
      nx = '0;
      nx.st = S_IDLE;
    end else if (spi_s) begin
      // shift-register path selected: two-wire slave stays deaf
      nx.st = S_IDLE;
      nx.sda_oe = 1'b0;
    end else if (start_seen) begin
      // a start, repeated or not, always restarts the address phase
      nx.st = S_ADDR;
      nx.cnt = 4'h0;
      nx.sda_oe = 1'b0;
    end else if (stop_seen) begin
      nx.st = S_IDLE;
      nx.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (cur.st)
        S_ADDR, S_RX: begin
          nx.shift = {cur.shift[6:0], sda_s};
          nx.cnt = cur.cnt + 4'h1;
        end
        S_TACK: nx.nack = sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (cur.st)
        S_IDLE: ;
        S_ADDR: begin
          if (cur.cnt == mux_switch_pkg::BITS_PER_BYTE) begin
            if (cur.shift[7:1] ==
                {mux_switch_pkg::SLAVE_ADDR_UPPER, asel_s}) begin
              nx.st = S_AACK;
              nx.sda_oe = 1'b1;
              nx.rw = cur.shift[0];
            end else begin
              nx.st = S_IDLE;
            end
          end
        end
        S_AACK: begin
          nx.cnt = 4'h0;
          if (cur.rw) begin
            nx.st = S_TX;
            nx.shift = rd_byte;
            nx.sda_oe = !rd_byte[7];
            nx.ptr = cur.ptr + 8'h01;
          end else begin
            nx.st = S_RX;
            nx.sda_oe = 1'b0;
            nx.got_ptr = 1'b0;
          end
        end
        S_RX: begin
          if (cur.cnt == mux_switch_pkg::BITS_PER_BYTE) begin
            if (!cur.got_ptr) begin
              nx.ptr = cur.shift;
              nx.got_ptr = 1'b1;
            end else begin
              // the whole byte is in: registers change only now
              nx = reg_write(cur, cur.ptr, cur.shift);
              nx.ptr = cur.ptr + 8'h01;
            end
            nx.st = S_RACK;
            nx.sda_oe = 1'b1;
            nx.cnt = 4'h0;
          end
        end
        S_RACK: begin
          nx.st = S_RX;
          nx.sda_oe = 1'b0;
        end
        S_TX: begin
          if (cur.cnt == mux_switch_pkg::BITS_PER_BYTE - 4'h1) begin
            nx.st = S_TACK;
            nx.sda_oe = 1'b0;
          end else begin
            nx.shift = {cur.shift[6:0], 1'b0};
            nx.sda_oe = !cur.shift[6];
            nx.cnt = cur.cnt + 4'h1;
          end
        end
        S_TACK: begin
          if (cur.nack) begin
            // master refused: stop sending until the next start
            nx.st = S_IDLE;
            nx.sda_oe = 1'b0;
          end else begin
            nx.st = S_TX;
            nx.shift = rd_byte;
            nx.sda_oe = !rd_byte[7];
            nx.ptr = cur.ptr + 8'h01;
            nx.cnt = 4'h0;
          end
        end
      endcase
    end
    // clock line only sampled, never driven
    nx.sync1 = {addr_sel_high, addr_sel_low, spi_sel, power_down_n,
                link.sda, link.scl};
    nx.sync2 = cur.sync1;
    nx.scl_prev = scl_s;
    nx.sda_prev = sda_s;
  end

  //--------------------------------------------------------------------
  // registers and outputs
  //--------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
      cur.st <= S_IDLE;
    end else begin
      cur <= nx;
    end
  end

  assign switch_en = cur.direct;
  assign link.sda_s_oe = cur.sda_oe;

endmodule
`default_nettype wire

// ==== mux_switch_master.sv ====
// two-wire bus controller driven from AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module mux_switch_master #(
  parameter int QUARTER = mux_switch_pkg::QUARTER_CYC
) (
  input wire logic core_clk,        // system clock
  input wire logic sys_rst,         // async reset, active high
  input wire logic awvalid,         // write address valid
  output logic awready,             // write address ready
  input wire logic [7:0] awaddr,    // write address
  input wire logic wvalid,          // write data valid
  output logic wready,              // write data ready
  input wire logic [31:0] wdata,    // write data
  input wire logic [3:0] wstrb,     // write byte enables
  output logic bvalid,              // write response valid
  input wire logic bready,          // write response ready
  output logic [1:0] bresp,         // write response
  input wire logic arvalid,         // read address valid
  output logic arready,             // read address ready
  input wire logic [7:0] araddr,    // read address
  output logic rvalid,              // read data valid
  input wire logic rready,          // read data ready
  output logic [31:0] rdata,        // read data
  output logic [1:0] rresp,         // read response
  i2c_link_if.master link           // serial link
);

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_START = 4'h2,
    H_BIT = 4'h4,
    H_STOP = 4'h8
  } host_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    host_state_t st;
    logic [15:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [8:0] rx9;
    logic scl_oe;
    logic sda_oe;
    logic nack;
    logic [7:0] rx;
    logic [10:0] last_cmd;
    logic awready, wready, aw_got, w_got, bvalid, arready, rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [1:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } host_regs_t;

  host_regs_t cur;
  host_regs_t nx;
  logic busy;
  logic tick;

  assign busy = (cur.st != H_IDLE);
  assign tick = (cur.qcnt == 16'(QUARTER - 1));

  always_comb begin
    nx = cur;
    nx.sync1 = link.sda;
    nx.sync2 = cur.sync1;
    //------------------------------------------------------------------
    // register slave
    //------------------------------------------------------------------
    if (awvalid && cur.awready) begin
      nx.aw_got = 1'b1;
      nx.awaddr = awaddr;
    end
    if (wvalid && cur.wready) begin
      nx.w_got = 1'b1;
      nx.wdata = wdata;
      nx.wstrb = wstrb[1:0];
    end
    if (cur.bvalid && bready) begin
      nx.bvalid = 1'b0;
    end
    if (cur.aw_got && cur.w_got && !cur.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = mux_switch_pkg::AXI_OKAY;
      if (cur.awaddr == mux_switch_pkg::AXI_CMD) begin
        // master starts every transfer; a command while busy is dropped
        if (cur.wstrb == 2'h3 && !busy) begin
          nx.last_cmd = cur.wdata[10:0];
          nx.qcnt = 16'h0000;
          nx.phase = 2'h0;
          nx.bitn = 4'h0;
          unique case (cur.wdata[10:8])
            mux_switch_pkg::OP_START: nx.st = H_START;
            mux_switch_pkg::OP_STOP: nx.st = H_STOP;
            mux_switch_pkg::OP_WRITE: begin
              nx.st = H_BIT;
              nx.sh = {cur.wdata[7:0], 1'b1};
            end
            mux_switch_pkg::OP_READ_ACK: begin
              nx.st = H_BIT;
              nx.sh = 9'h1FE;
            end
            mux_switch_pkg::OP_READ_NACK: begin
              nx.st = H_BIT;
              nx.sh = 9'h1FF;
            end
            default: ;
          endcase
        end
      end else if (cur.awaddr != mux_switch_pkg::AXI_STATUS) begin
        nx.bresp = mux_switch_pkg::AXI_SLVERR;
      end
    end
    if (cur.rvalid && rready) begin
      nx.rvalid = 1'b0;
    end
    if (arvalid && cur.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = mux_switch_pkg::AXI_OKAY;
      if (araddr == mux_switch_pkg::AXI_CMD) begin
        nx.rdata = {21'h000000, cur.last_cmd};
      end else if (araddr == mux_switch_pkg::AXI_STATUS) begin
        nx.rdata = {16'h0000, cur.rx, 6'h00, cur.nack, busy};
      end else begin
        nx.rdata = 32'h00000000;
        nx.rresp = mux_switch_pkg::AXI_SLVERR;
      end
    end
    //------------------------------------------------------------------
    // bit engine, four quarter periods per step
    //------------------------------------------------------------------
    if (busy) begin
      nx.qcnt = tick ? 16'h0000 : cur.qcnt + 16'h0001;
      if (tick) begin
        nx.phase = cur.phase + 2'h1;
        unique case (cur.st)
          H_START: begin
            unique case (cur.phase)
              2'h0: begin
                nx.sda_oe = 1'b0;
                nx.scl_oe = 1'b1;
              end
              2'h1: nx.scl_oe = 1'b0;
              2'h2: nx.sda_oe = 1'b1;
              2'h3: begin
                nx.scl_oe = 1'b1;
                nx.st = H_IDLE;
              end
            endcase
          end
          H_BIT: begin
            unique case (cur.phase)
              2'h0: begin
                nx.scl_oe = 1'b1;
                nx.sda_oe = !cur.sh[8];
              end
              2'h1: nx.scl_oe = 1'b0;
              2'h2: nx.rx9 = {cur.rx9[7:0], cur.sync2};
              2'h3: begin
                nx.scl_oe = 1'b1;
                nx.sh = {cur.sh[7:0], 1'b1};
                nx.bitn = cur.bitn + 4'h1;
                if (cur.bitn == mux_switch_pkg::BITS_PER_BYTE) begin
                  nx.st = H_IDLE;
                  nx.rx = cur.rx9[8:1];
                  nx.nack = cur.rx9[0];
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (cur.phase)
              2'h0: begin
                nx.scl_oe = 1'b1;
                nx.sda_oe = 1'b1;
              end
              2'h1: nx.scl_oe = 1'b0;
              2'h2: nx.sda_oe = 1'b0;
              2'h3: nx.st = H_IDLE;
            endcase
          end
          default: ;
        endcase
      end
    end
    nx.awready = !nx.aw_got && !nx.bvalid;
    nx.wready = !nx.w_got && !nx.bvalid;
    nx.arready = !nx.rvalid;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
      cur.st <= H_IDLE;
    end else begin
      cur <= nx;
    end
  end

  assign awready = cur.awready;
  assign wready = cur.wready;
  assign bvalid = cur.bvalid;
  assign bresp = cur.bresp;
  assign arready = cur.arready;
  assign rvalid = cur.rvalid;
  assign rdata = cur.rdata;
  assign rresp = cur.rresp;
  assign link.scl_m_oe = cur.scl_oe;
  assign link.sda_m_oe = cur.sda_oe;

endmodule
`default_nettype wire

// ==== mux_switch_sva.sv ====
// assertions on the two-wire link between the controller and the slave
`timescale 1ns/1ns
`default_nettype none
module mux_switch_sva (
  input wire logic core_clk,       // system clock
  input wire logic sys_rst,        // async reset, active high
  input wire logic power_down_n,   // shutdown pin, active low
  input wire logic spi_sel,        // protocol select
  input wire logic scl_m_oe,       // master pulls clock low
  input wire logic sda_m_oe,       // master pulls data low
  input wire logic sda_s_oe,       // slave pulls data low
  input wire logic scl,            // clock wire level
  input wire logic sda,            // data wire level
  input wire logic [31:0] switch_en // switch enables
);
  //--------------------------------------------------------------------
  // cycles spent in shutdown or with the shift path selected
  //--------------------------------------------------------------------
  logic [2:0] pd_cnt;
  logic [2:0] sel_cnt;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_cnt <= 3'h0;
      sel_cnt <= 3'h0;
    end else begin
      pd_cnt <= power_down_n ? 3'h0 : pd_cnt + {2'h0, pd_cnt != 3'h7};
      sel_cnt <= !spi_sel ? 3'h0 : sel_cnt + {2'h0, sel_cnt != 3'h7};
    end
  end

  //--------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_pd_clears: assert property ($fell(power_down_n) |-> ##5
    (switch_en == 32'h0000_0000) [*3])
    else $error("switches kept in shutdown");
  a_pd_quiet: assert property (pd_cnt >= 3'h5 |-> !sda_s_oe)
    else $error("slave drives data line in shutdown");
  a_sel_quiet: assert property (sel_cnt >= 3'h5 |-> !sda_s_oe)
    else $error("slave drives data line with shift path selected");
  a_ack_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave changed data line while clock high");
  a_no_slave_start: assert property (($changed(sda) && scl) |->
    (!sda_s_oe && !$past(sda_s_oe))) else $error("slave made a bus condition");
  a_stop_quiet: assert property (($rose(sda) && scl) |=>
    !sda_s_oe [*4]) else $error("slave drives data line after stop");
  a_scl_input: assert property (!scl_m_oe |-> scl)
    else $error("clock line held low by slave");
  a_switch_scl_low: assert property (
    ($changed(switch_en) && power_down_n) |-> !scl)
    else $error("switches changed while clock high");

  c_ack: cover property (sda_s_oe && scl);
  c_switch: cover property ($changed(switch_en) && switch_en != 32'h0000_0000);
  c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench: bus controller and switch slave joined by the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk, sys_rst, power_down_n, spi_sel;
  logic [1:0] addr_sel;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, switch_en;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int num_errors, n_compared;

  i2c_link_if link();
  mux_switch_master #(.QUARTER(5)) mux_switch_master_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .link(link));
  mux_switch_slave mux_switch_slave_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .power_down_n(power_down_n),
    .spi_sel(spi_sel), .addr_sel_low(addr_sel[0]),
    .addr_sel_high(addr_sel[1]), .link(link), .switch_en(switch_en));
  mux_switch_sva mux_switch_sva_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .power_down_n(power_down_n),
    .spi_sel(spi_sel), .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe),
    .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda),
    .switch_en(switch_en));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  //--------------------------------------------------------------------
  // bus tasks
  //--------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one link operation, then poll status until the controller is idle
  task automatic op(input logic [2:0] c, input logic [7:0] b,
                    output logic [31:0] st);
    logic [1:0] r;
    axi_wr(mux_switch_pkg::AXI_CMD, {21'h0, c, b}, r);
    do axi_rd(mux_switch_pkg::AXI_STATUS, st, r); while (st[0] !== 1'b0);
  endtask

  task automatic wbyte(input logic [7:0] b, input logic nack);
    logic [31:0] st;
    op(mux_switch_pkg::OP_WRITE, b, st);
    chk({31'h0, st[1]}, {31'h0, nack});
  endtask

  task automatic rbyte(input logic [2:0] c, input logic [7:0] exp);
    logic [31:0] st;
    op(c, 8'h00, st);
    chk({24'h0, st[15:8]}, {24'h0, exp});
  endtask

  task automatic cond(input logic [2:0] c);
    logic [31:0] st;
    op(c, 8'h00, st);
  endtask

  // write n bytes from d, lowest byte first, starting at register rg
  task automatic wr_seq(input logic [7:0] rg, input int n,
                        input logic [31:0] d);
    cond(mux_switch_pkg::OP_START);
    wbyte(8'h9A, 1'b0);
    wbyte(rg, 1'b0);
    for (int i = 0; i < n; i++) begin
      wbyte(d[8*i +: 8], 1'b0);
    end
    cond(mux_switch_pkg::OP_STOP);
  endtask

  //--------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h08, 32'h0000_0000, r);
    chk({30'h0, r}, {30'h0, mux_switch_pkg::AXI_SLVERR});
    axi_rd(8'h08, d, r);
    chk({30'h0, r}, {30'h0, mux_switch_pkg::AXI_SLVERR});
  endtask

  task automatic t_direct();
    wr_seq(8'h00, 4, 32'h4433_2211);
    chk(switch_en, 32'h4433_2211);
  endtask

  task automatic t_read();
    wr_seq(8'h01, 0, 32'h0000_0000);
    chk(switch_en, 32'h4433_2211);
    cond(mux_switch_pkg::OP_START);
    wbyte(8'h9B, 1'b0);
    rbyte(mux_switch_pkg::OP_READ_ACK, 8'h22);
    rbyte(mux_switch_pkg::OP_READ_ACK, 8'h33);
    rbyte(mux_switch_pkg::OP_READ_NACK, 8'h44);
    cond(mux_switch_pkg::OP_STOP);
  endtask

  task automatic t_staged();
    wr_seq(8'h10, 4, 32'h3CC3_5AA5);
    chk(switch_en, 32'h4433_2211);
    wr_seq(8'h14, 1, 32'h0000_0011);
    chk(switch_en, 32'h4433_2211);
    wr_seq(8'h15, 1, 32'h0000_0011);
    chk(switch_en, 32'h3CC3_5AA5);
  endtask

  task automatic t_cmds();
    wr_seq(8'h14, 2, 32'h0000_1003);
    chk(switch_en, 32'h0000_0008);
    wr_seq(8'h14, 2, 32'h0000_0F12);
    chk(switch_en, 32'h8000_0008);
    wr_seq(8'h14, 2, 32'h0000_1210);
    chk(switch_en, 32'h8000_0000);
  endtask

  task automatic t_refused();
    logic [31:0] d;
    logic [1:0] r;
    cond(mux_switch_pkg::OP_START);
    wbyte(8'h98, 1'b1);
    cond(mux_switch_pkg::OP_STOP);
    addr_sel <= 2'h0;
    repeat (4) @(posedge core_clk);
    cond(mux_switch_pkg::OP_START);
    wbyte(8'h98, 1'b0);
    cond(mux_switch_pkg::OP_STOP);
    addr_sel <= 2'h1;
    @(posedge core_clk);
    spi_sel <= 1'b1;
    repeat (6) @(posedge core_clk);
    cond(mux_switch_pkg::OP_START);
    wbyte(8'h9A, 1'b1);
    cond(mux_switch_pkg::OP_STOP);
    spi_sel <= 1'b0;
    power_down_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(switch_en, 32'h0000_0000);
    cond(mux_switch_pkg::OP_START);
    wbyte(8'h9A, 1'b1);
    cond(mux_switch_pkg::OP_STOP);
    power_down_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    wr_seq(8'h00, 1, 32'h0000_005A);
    chk(switch_en, 32'h0000_005A);
    axi_rd(mux_switch_pkg::AXI_CMD, d, r);
    chk(d, {21'h0, mux_switch_pkg::OP_STOP, 8'h00});
  endtask

  task automatic results();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    power_down_n = 1'b1;
    spi_sel = 1'b0;
    addr_sel = 2'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(switch_en, 32'h0000_0000);
    t_unmapped();
    t_direct();
    t_read();
    t_staged();
    t_cmds();
    t_refused();
    results();
  end
endmodule
`default_nettype wire
